// [sim/uab_peer.sv]
// Peer node on the multidrop line plus the outside timer overflow source.
// Assumes the bench calls send_frame and sets tmr_period; all on mclk.
`timescale 1ns/100ps
module uab_peer (
  input wire logic mclk,
  output logic frame_valid,
  output uab_pkg::uab_frame_t frame_in,
  output logic timer_overflow
);
  int tmr_period = 0;
  int tmr_cnt = 0;
  initial begin
    frame_valid = 1'b0;
    frame_in = '0;
    timer_overflow = 1'b0;
  end
  // Address frames go out with the marker set, data frames with it clear
  task automatic send_frame(input logic [7:0] d, input logic mk);
    @(posedge mclk);
    frame_valid <= 1'b1;
    frame_in <= {d, mk};
    @(posedge mclk);
    frame_valid <= 1'b0;
    // Line is not held after the frame, so never show the old value
    frame_in <= ~frame_in;
  endtask : send_frame
  always @(posedge mclk) begin
    if (tmr_period > 0 && tmr_cnt >= tmr_period - 1) begin
      tmr_cnt <= 0;
      timer_overflow <= 1'b1;
    end else begin
      tmr_cnt <= tmr_cnt + 1;
      timer_overflow <= 1'b0;
    end
  end
endmodule : uab_peer

// [sim/uab_top_tb.sv]
// Self-checking bench: APB register access, address filter, bit rates.
// Assumes uab_peer drives frames and timer overflow pulses.
`timescale 1ns/100ps
`include "uab_defines.svh"
`define CHECK_EQ(got, exp, msg) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("CHECK FAILED t=%0t %s", $time, msg); \
    end \
  end
module uab_top_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  uab_pkg::uab_mode_t serial_mode = uab_pkg::UAB_MODE_SYNC;
  logic frame_valid;
  logic timer_overflow;
  uab_pkg::uab_frame_t frame_in;
  logic receive_done_flag;
  logic addr_match;
  logic tx_bit_tick;
  logic rx_bit_tick;
  int error_cnt = 0;
  int samples_checked = 0;
  int cnt;
  logic [7:0] cur_addr = 8'h00;
  logic [7:0] cur_mask = 8'h00;
  logic [31:0] rd;
  logic err;

  always #25 mclk = ~mclk;

  uab_top u_uab_top (.mclk(mclk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_mode(serial_mode), .frame_valid(frame_valid),
    .frame_in(frame_in), .timer_overflow(timer_overflow),
    .receive_done_flag(receive_done_flag), .addr_match(addr_match),
    .tx_bit_tick(tx_bit_tick), .rx_bit_tick(rx_bit_tick));
  uab_peer u_uab_peer (.mclk(mclk), .frame_valid(frame_valid),
    .frame_in(frame_in), .timer_overflow(timer_overflow));

  task automatic report_and_stop();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic timeout();
    error_cnt++;
    $display("CHECK FAILED t=%0t wait timed out", $time);
    report_and_stop();
  endtask : timeout

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) timeout();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic frame_case(input logic [1:0] m, input logic mp,
                            input logic [7:0] d, input logic mk);
    logic [7:0] b;
    logic h;
    logic ex;
    logic am;
    b = cur_addr | cur_mask;
    h = ((((d ^ cur_addr) & cur_mask) == 8'h00) ||
         (((d ^ b) & b) == 8'h00));
    am = mp && (m != 2'h0) && mk && h;
    ex = !(mp && m != 2'h0) || (mk && h);
    serial_mode <= uab_pkg::uab_mode_t'(m);
    apb(1'b1, `UAB_OFF_CTRL, {31'h0000_0000, mp});
    u_uab_peer.send_frame(d, mk);
    @(posedge mclk);
    #1;
    `CHECK_EQ(receive_done_flag, ex, "receive flag")
    `CHECK_EQ(addr_match, am, "address match")
    apb(1'b1, `UAB_OFF_STATUS, 32'h0000_0001);
    @(posedge mclk);
    #1;
    `CHECK_EQ(receive_done_flag, 1'b0, "receive flag clear")
  endtask : frame_case

  task automatic gap(input logic tx, output int n);
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while ((tx ? tx_bit_tick : rx_bit_tick) !== 1'b1 && n < 2000);
    if (n >= 2000) timeout();
  endtask : gap

  // Third gap is measured: the first two may span the divider restart
  task automatic rate_case(input logic [1:0] m, input logic dbl,
                           input logic [7:0] rate, input logic [7:0] rl,
                           input int etx, input int erx);
    int g;
    serial_mode <= uab_pkg::uab_mode_t'(m);
    apb(1'b1, `UAB_OFF_CTRL, {30'h0000_0000, dbl, 1'b0});
    apb(1'b1, `UAB_OFF_RELOAD, {24'h00_0000, rl});
    apb(1'b1, `UAB_OFF_RATE, {24'h00_0000, rate});
    for (int s = 0; s < 2; s++) begin
      repeat (3) gap(s == 0, g);
      `CHECK_EQ(g, (s == 0) ? etx : erx, "bit period")
    end
  endtask : rate_case

  initial begin
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    u_uab_peer.tmr_period = 3;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0000_0000);
      `CHECK_EQ(rd, 32'h0000_0000, "reset value")
    end
    apb(1'b0, 8'h18, 32'h0000_0000);
    `CHECK_EQ({err, rd}, {1'b1, 32'h0000_0000}, "unmapped read")
    apb(1'b1, `UAB_OFF_RELOAD, 32'h0000_00A5);
    apb(1'b0, `UAB_OFF_RELOAD, 32'h0000_0000);
    `CHECK_EQ(rd, 32'h0000_00A5, "reload readback")
    frame_case(2'h3, 1'b1, 8'h33, 1'b1);
    cur_addr = 8'h56;
    cur_mask = 8'hFC;
    apb(1'b1, `UAB_OFF_SLV_ADDR, {24'h00_0000, cur_addr});
    apb(1'b1, `UAB_OFF_SLV_MASK, {24'h00_0000, cur_mask});
    frame_case(2'h3, 1'b1, 8'h57, 1'b1);
    frame_case(2'h3, 1'b1, 8'h5A, 1'b1);
    frame_case(2'h3, 1'b1, 8'hFF, 1'b1);
    frame_case(2'h2, 1'b1, 8'h54, 1'b0);
    frame_case(2'h1, 1'b1, 8'h55, 1'b0);
    frame_case(2'h1, 1'b1, 8'h55, 1'b1);
    frame_case(2'h0, 1'b1, 8'h5A, 1'b0);
    frame_case(2'h3, 1'b0, 8'h5A, 1'b0);
    // Frame lands on the same edge as the clear write: set must win
    u_uab_peer.send_frame(8'h5A, 1'b0);
    fork
      apb(1'b1, `UAB_OFF_STATUS, 32'h0000_0001);
      begin
        repeat (2) @(posedge mclk);
        u_uab_peer.send_frame(8'h5A, 1'b0);
      end
    join
    @(posedge mclk);
    #1;
    `CHECK_EQ(receive_done_flag, 1'b1, "set against clear")
    rate_case(2'h2, 1'b0, 8'h00, 8'h00, 64, 64);
    rate_case(2'h2, 1'b1, 8'h00, 8'h00, 32, 32);
    rate_case(2'h0, 1'b0, 8'h00, 8'h00, 12, 12);
    rate_case(2'h0, 1'b0, 8'h13, 8'hFE, 4 * 2, 4 * 2);
    rate_case(2'h0, 1'b0, 8'h11, 8'hFE, 24 * 2, 24 * 2);
    rate_case(2'h3, 1'b0, 8'h1A, 8'hFF, 64, 32 * 3);
    rate_case(2'h1, 1'b1, 8'h1A, 8'hFF, 32, 16 * 3);
    rate_case(2'h3, 1'b0, 8'h14, 8'hFF, 32 * 3, 384);
    apb(1'b1, `UAB_OFF_RATE, 32'h0000_0008);
    repeat (10) @(posedge mclk);
    cnt = 0;
    repeat (800) begin
      @(posedge mclk);
      if (tx_bit_tick === 1'b1) cnt++;
    end
    `CHECK_EQ(cnt, 0, "halted generator ticks")
    report_and_stop();
  end
endmodule : uab_top_tb

// [verilog/uab_bit_div.sv]
// Divides a source pulse train down to one bit-rate enable pulse.
// Assumes src_pulse is a one-cycle enable on mclk.
`timescale 1ns/100ps
`include "uab_defines.svh"
module uab_bit_div (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic restart,
  input wire logic src_pulse,
  input wire logic [6:0] div_len,
  output logic tick_q
);
  logic [6:0] count_q;
  logic last;

  assign last = (count_q >= 7'(div_len - `UAB_DIV_ONE));

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= 7'h00;
      tick_q <= 1'b0;
    end else if (restart) begin
      count_q <= 7'h00;
      tick_q <= 1'b0;
    end else begin
      tick_q <= src_pulse & last;
      if (src_pulse) begin
        count_q <= last ? 7'h00 : 7'(count_q + 7'h01);
      end
    end
  end
endmodule : uab_bit_div

// [verilog/uab_defines.svh]
// Register offsets, field positions, reset values and divider counts
// for the serial address filter and bit-rate generator.
// Assumes byte addresses on a 32-bit APB bus, one register per word.
`ifndef UAB_DEFINES_SVH
`define UAB_DEFINES_SVH

`define UAB_OFF_CTRL 8'h00
`define UAB_OFF_SLV_ADDR 8'h04
`define UAB_OFF_SLV_MASK 8'h08
`define UAB_OFF_RATE 8'h0C
`define UAB_OFF_RELOAD 8'h10
`define UAB_OFF_STATUS 8'h14

`define UAB_CTRL_MP_BIT 0
`define UAB_CTRL_DRS_BIT 1
`define UAB_STAT_DONE_BIT 0
`define UAB_STAT_MATCH_BIT 1

`define UAB_RST_ADDR 8'h00
`define UAB_RST_RELOAD 8'h00
`define UAB_RST_RATE 5'h00

`define UAB_PRE_SLOW_LAST 4'hB
`define UAB_GEN_TOP 8'hFF
`define UAB_DIV_ONE 7'h01
`define UAB_DIV_SYNC_GEN 7'h02
`define UAB_DIV_ASYNC 7'h20
`define UAB_DIV_ASYNC_DBL 7'h10
`define UAB_DIV_FIXED 7'h40
`define UAB_DIV_FIXED_DBL 7'h20

`endif

// [verilog/uab_pkg.sv]
// Types shared by the address filter / bit-rate generator files.
// Assumes uab_defines.svh carries all numeric constants.
package uab_pkg;
  typedef enum logic [1:0] {
    UAB_MODE_SYNC = 2'b00,
    UAB_MODE_ASYNC10 = 2'b01,
    UAB_MODE_FIXED11 = 2'b10,
    UAB_MODE_VAR11 = 2'b11
  } uab_mode_t;

  typedef struct packed {
    logic generator_run;
    logic tx_clock_select;
    logic rx_clock_select;
    logic generator_speed_select;
    logic sync_clock_source_select;
  } uab_rate_ctrl_t;

  typedef struct packed {
    logic [7:0] data;
    logic marker;
  } uab_frame_t;

  typedef struct packed {
    logic pulse;
    logic [6:0] len;
  } uab_clk_pick_t;
endpackage : uab_pkg

// [verilog/uab_top.sv]
// Serial-port address filter and bit-rate generator with APB registers.
// Assumes a framer supplies received frames and the serial mode, and an
// outside timer supplies its overflow pulse; all on mclk.
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "uab_defines.svh"

module uab_top (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire uab_pkg::uab_mode_t serial_mode,
  input wire logic frame_valid,
  input wire uab_pkg::uab_frame_t frame_in,
  input wire logic timer_overflow,
  output logic receive_done_flag,
  output logic addr_match,
  output logic tx_bit_tick,
  output logic rx_bit_tick
);
  logic multiproc_enable_q;
  logic double_rate_select_q;
  logic [7:0] slave_address_q;
  logic [7:0] slave_address_mask_q;
  logic [7:0] generator_reload_value_q;
  uab_pkg::uab_rate_ctrl_t rate_ctrl_q;
  logic receive_done_q;
  logic addr_match_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic cfg_wr_q;
  logic [3:0] pre_cnt_q;
  logic [7:0] gen_cnt_q;
  logic gen_ovf_q;
  logic tick12;
  logic gen_tick;
  logic wr_en;
  logic rd_en;
  logic filter_active;
  logic frame_hit;
  logic frame_take;
  logic done_clear;
  logic [7:0] broadcast_addr;
  uab_pkg::uab_clk_pick_t tx_pick;
  uab_pkg::uab_clk_pick_t rx_pick;

  // Masked compare: only bits where care is one must agree
  function automatic logic addr_hit(input logic [7:0] rx,
                                    input logic [7:0] addr,
                                    input logic [7:0] care);
    addr_hit = (((rx ^ addr) & care) == 8'h00);
  endfunction : addr_hit

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `UAB_OFF_CTRL) || (a == `UAB_OFF_SLV_ADDR) ||
             (a == `UAB_OFF_SLV_MASK) || (a == `UAB_OFF_RATE) ||
             (a == `UAB_OFF_RELOAD) || (a == `UAB_OFF_STATUS);
  endfunction : mapped

  // Chooses source pulse and divide length for one direction
  function automatic uab_pkg::uab_clk_pick_t pick_clk(
      input uab_pkg::uab_mode_t mode,
      input logic dir_sel,
      input logic src_sel,
      input logic dbl,
      input logic g_ovf,
      input logic t12,
      input logic t_ovf);
    uab_pkg::uab_clk_pick_t p;
    p = '0;
    unique case (mode)
      uab_pkg::UAB_MODE_SYNC: begin
        if (src_sel) begin
          p.pulse = g_ovf;
          p.len = `UAB_DIV_SYNC_GEN;
        end else begin
          p.pulse = t12;
          p.len = `UAB_DIV_ONE;
        end
      end
      uab_pkg::UAB_MODE_FIXED11: begin
        p.pulse = 1'b1;
        p.len = dbl ? `UAB_DIV_FIXED_DBL : `UAB_DIV_FIXED;
      end
      uab_pkg::UAB_MODE_ASYNC10, uab_pkg::UAB_MODE_VAR11: begin
        p.pulse = dir_sel ? g_ovf : t_ovf;
        p.len = dbl ? `UAB_DIV_ASYNC_DBL : `UAB_DIV_ASYNC;
      end
    endcase
    pick_clk = p;
  endfunction : pick_clk

  // APB: access phase takes two cycles, pready registered
  assign wr_en = psel & penable & pwrite & pready_q & ~pslverr_q;
  assign rd_en = psel & penable & ~pready_q;
  assign done_clear = wr_en && (paddr == `UAB_OFF_STATUS) &&
                      pwdata[`UAB_STAT_DONE_BIT];

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= rd_en;
      pslverr_q <= rd_en & ~mapped(paddr);
      if (rd_en & ~pwrite) begin
        unique case (paddr)
          `UAB_OFF_CTRL: prdata_q <= {30'h0000_0000,
                                      double_rate_select_q,
                                      multiproc_enable_q};
          `UAB_OFF_SLV_ADDR: prdata_q <= {24'h00_0000, slave_address_q};
          `UAB_OFF_SLV_MASK: prdata_q <= {24'h00_0000, slave_address_mask_q};
          `UAB_OFF_RATE: prdata_q <= {27'h000_0000, rate_ctrl_q};
          `UAB_OFF_RELOAD: prdata_q <= {24'h00_0000,
                                        generator_reload_value_q};
          `UAB_OFF_STATUS: prdata_q <= {30'h0000_0000, addr_match_q,
                                        receive_done_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end else if (!psel) begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // Control registers written by software
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      multiproc_enable_q <= 1'b0;
      double_rate_select_q <= 1'b0;
      slave_address_q <= `UAB_RST_ADDR;
      slave_address_mask_q <= `UAB_RST_ADDR;
      generator_reload_value_q <= `UAB_RST_RELOAD;
      rate_ctrl_q <= `UAB_RST_RATE;
      cfg_wr_q <= 1'b0;
    end else begin
      cfg_wr_q <= wr_en && ((paddr == `UAB_OFF_RATE) ||
                            (paddr == `UAB_OFF_CTRL));
      if (wr_en) begin
        unique case (paddr)
          `UAB_OFF_CTRL: begin
            multiproc_enable_q <= pwdata[`UAB_CTRL_MP_BIT];
            double_rate_select_q <= pwdata[`UAB_CTRL_DRS_BIT];
          end
          `UAB_OFF_SLV_ADDR: slave_address_q <= pwdata[7:0];
          `UAB_OFF_SLV_MASK: slave_address_mask_q <= pwdata[7:0];
          `UAB_OFF_RATE: rate_ctrl_q <= pwdata[4:0];
          `UAB_OFF_RELOAD: generator_reload_value_q <= pwdata[7:0];
          default: begin
          end
        endcase
      end
    end
  end

  // Address filter
  assign broadcast_addr = slave_address_q | slave_address_mask_q;
  // Sync mode never filters, whatever multiproc_enable says
  assign filter_active = multiproc_enable_q &&
                         (serial_mode != uab_pkg::UAB_MODE_SYNC);
  assign frame_hit =
      addr_hit(frame_in.data, slave_address_q, slave_address_mask_q) ||
      addr_hit(frame_in.data, broadcast_addr, broadcast_addr);
  // Marker is the ninth bit, or the valid stop bit in 10-bit mode
  assign frame_take = frame_valid &&
                      (!filter_active || (frame_in.marker && frame_hit));

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      receive_done_q <= 1'b0;
      addr_match_q <= 1'b0;
    end else begin
      // A frame landing with the clear still sets the flag
      if (frame_take) begin
        receive_done_q <= 1'b1;
      end else if (done_clear) begin
        receive_done_q <= 1'b0;
      end
      if (frame_valid) begin
        addr_match_q <= filter_active && frame_in.marker && frame_hit;
      end
    end
  end

  // Prescaler: mclk/12 tick, and mclk/2 tick for the fast generator
  assign tick12 = (pre_cnt_q == `UAB_PRE_SLOW_LAST);
  assign gen_tick = rate_ctrl_q.generator_speed_select ? pre_cnt_q[0]
                                                       : tick12;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_cnt_q <= 4'h0;
    end else begin
      pre_cnt_q <= tick12 ? 4'h0 : 4'(pre_cnt_q + 4'h1);
    end
  end

  // Internal generator: overflow every (256 - reload) ticks
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      gen_cnt_q <= 8'h00;
      gen_ovf_q <= 1'b0;
    end else begin
      gen_ovf_q <= 1'b0;
      if (rate_ctrl_q.generator_run && gen_tick) begin
        if (gen_cnt_q == `UAB_GEN_TOP) begin
          gen_cnt_q <= generator_reload_value_q;
          gen_ovf_q <= 1'b1;
        end else begin
          gen_cnt_q <= 8'(gen_cnt_q + 8'h01);
        end
      end
    end
  end

  // Per-direction source selection and division
  always_comb begin
    tx_pick = pick_clk(serial_mode, rate_ctrl_q.tx_clock_select,
                       rate_ctrl_q.sync_clock_source_select,
                       double_rate_select_q, gen_ovf_q, tick12,
                       timer_overflow);
    rx_pick = pick_clk(serial_mode, rate_ctrl_q.rx_clock_select,
                       rate_ctrl_q.sync_clock_source_select,
                       double_rate_select_q, gen_ovf_q, tick12,
                       timer_overflow);
  end

  uab_bit_div u_tx_div (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .restart(cfg_wr_q),
    .src_pulse(tx_pick.pulse),
    .div_len(tx_pick.len),
    .tick_q(tx_bit_tick)
  );

  uab_bit_div u_rx_div (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .restart(cfg_wr_q),
    .src_pulse(rx_pick.pulse),
    .div_len(rx_pick.len),
    .tick_q(rx_bit_tick)
  );

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign receive_done_flag = receive_done_q;
  assign addr_match = addr_match_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  a_nomatch_no_flag: assert property (
    (filter_active && frame_valid && !frame_hit && !receive_done_q)
    |=> !receive_done_q)
    else $error("Flag set by a non-matching address frame");

  a_marker_needed: assert property (
    (filter_active && frame_valid && !frame_in.marker && !receive_done_q)
    |=> !receive_done_q)
    else $error("Flag set by a frame without marker");

  a_sync_ignores_mp: assert property (
    (frame_valid && serial_mode == uab_pkg::UAB_MODE_SYNC)
    |=> receive_done_q)
    else $error("Sync-mode frame did not set the flag");

  a_bcast_hit: assert property (
    (filter_active && frame_valid && frame_in.marker &&
     ((frame_in.data & broadcast_addr) == broadcast_addr))
    |=> receive_done_q)
    else $error("Broadcast address not accepted");

  a_unfiltered_take: assert property (
    (!multiproc_enable_q && frame_valid) |=> receive_done_q)
    else $error("Unfiltered frame did not set the flag");

  a_given_hit: assert property (
    (filter_active && frame_valid && frame_in.marker &&
     (((frame_in.data ^ slave_address_q) & slave_address_mask_q) == 8'h00))
    |=> receive_done_q)
    else $error("Individual address not accepted");

  a_set_wins: assert property (
    (frame_take && done_clear) |=> receive_done_q)
    else $error("Clear beat a simultaneous set");

  a_div12_period: assert property (
    tick12 |=> !tick12 [*8] ##1 !tick12 [*3] ##1 tick12)
    else $error("Fixed prescaler tick not every 12 cycles");

  a_gen_halted: assert property (
    !rate_ctrl_q.generator_run |=> $stable(gen_cnt_q) && !gen_ovf_q)
    else $error("Generator moved while stopped");

  a_gen_reload: assert property (
    (rate_ctrl_q.generator_run && gen_tick && gen_cnt_q == `UAB_GEN_TOP)
    |=> gen_ovf_q && gen_cnt_q == $past(generator_reload_value_q))
    else $error("Generator did not reload on overflow");

  a_fixed_rate: assert property (
    (serial_mode == uab_pkg::UAB_MODE_FIXED11 && !double_rate_select_q &&
     tx_bit_tick && !cfg_wr_q) |=> !tx_bit_tick [*8])
    else $error("Fixed-rate tick too close");

  a_apb_answer: assert property (
    (psel && penable && !pready_q) |=> pready_q)
    else $error("APB access not answered in one wait cycle");

endmodule : uab_top
